// >>> poa_dwell_timer.sv
module poa_dwell_timer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [16:0] tenths,
  input wire logic freeze,
  input wire logic abort,
  output logic done
);
  import poa_pkg::*;

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  logic [11:0] div_ff, nxt_div;
  logic [16:0] left_ff, nxt_left;
  logic run_ff, nxt_run;
  logic done_ff, nxt_done;

  // ----------------------------------------
  // 0.1 ms divider and dwell count
  // ----------------------------------------
  // Hold freezes the divider too, so resumed dwell keeps its remainder
  always_comb begin
    nxt_div = div_ff;
    nxt_left = left_ff;
    nxt_run = run_ff;
    nxt_done = 1'b0;
    if (abort) begin
      nxt_run = 1'b0;
    end else if (start) begin
      nxt_run = 1'b1;
      nxt_left = tenths;
      nxt_div = TICK_LAST;
    end else if (run_ff && !freeze) begin
      if (div_ff != 12'h000) begin
        nxt_div = div_ff - 12'h001;
      end else if (left_ff <= 17'h00001) begin
        nxt_run = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_left = left_ff - 17'h00001;
        nxt_div = TICK_LAST;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 12'h000;
      left_ff <= 17'h00000;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      left_ff <= nxt_left;
      run_ff <= nxt_run;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

  property p_dwell_min;
    @(posedge mclk) disable iff (!resetn)
    start |=> !done_ff [*8];
  endproperty
  a_dwell_min: assert property (p_dwell_min) else $error("dwell ended too early");

endmodule

// >>> poa_host_model.sv
module poa_host_model (
  input wire logic mclk,
  input wire logic run_req,
  input wire logic hold_req,
  input wire logic [3:0] delay,
  input wire logic move_valid,
  output logic [7:0] pin_in,
  output logic move_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Contacts and motor
  // ----------------------------------------
  logic [4:0] cnt_ff = 5'h00;
  logic [7:0] spin_ff = 8'h00;
  // Unwired ports toggle so a stuck read shows; servo pin left open
  assign pin_in = {spin_ff[7], ~hold_req, spin_ff[5], 1'b0, spin_ff[3:1], ~run_req};
  initial move_done = 1'b0;
  always @(posedge mclk) begin
    spin_ff <= spin_ff + 8'h01;
    move_done <= (cnt_ff == 5'h01);
    if (move_valid) begin
      cnt_ff <= {1'b0, delay} + 5'h01;
    end else if (cnt_ff != 5'h00) begin
      cnt_ff <= cnt_ff - 5'h01;
    end
  end
endmodule

// >>> poa_pkg.sv
package poa_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int DWELL_UNIT_NS = 100000;
  localparam int TICK_CYCLES = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS = 5000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Sizes and limits
  // ----------------------------------------
  localparam int N_IN = 8;
  localparam int N_OUT = 4;
  localparam int CH_W = 8;
  localparam int LINE_W = 3;
  localparam int ADDR_W = CH_W + LINE_W;
  localparam logic [LINE_W-1:0] LINE_FIRST = 3'h0;
  localparam logic [LINE_W-1:0] LINE_LAST = 3'h7;
  localparam logic [8:0] AUTOSTART_OFF = 9'h1FF;
  localparam logic [8:0] AUTOSTART_RESET = 9'h1FF;
  localparam logic [31:0] CH_MAX = 32'h000000FF;
  localparam logic [31:0] MINUS_ONE = 32'hFFFFFFFF;
  localparam logic [21:0] DIV_MIN = 22'h000001;
  localparam logic [21:0] DIV_MAX = 22'h280000;
  localparam logic [21:0] DIV_RESET = 22'h057E40;
  localparam logic [31:0] MOVE_SCALE = 32'h00000064;
  localparam logic [16:0] DWELL_MIN = 17'h00001;
  localparam logic [16:0] DWELL_MAX = 17'h186A0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {OP_END, OP_MOVE, OP_DWELL, OP_GOTO} poa_op_t;
  typedef struct packed {
    poa_op_t op;
    logic [31:0] arg;
  } poa_instr_t;
  typedef enum logic [2:0] {IN_NONE, IN_EMERGENCY_HALT_INPUT, IN_HOLD, IN_SERVO_ENABLE_INPUT, IN_STOP} poa_in_fn_t;
  typedef enum logic [2:0] {OUT_NONE, OUT_DRIVE_READY_FUNCTION, OUT_HEALTH, OUT_IN_POSITION_OUTPUT, OUT_BUSY} poa_out_fn_t;
  typedef struct packed {
    poa_in_fn_t fn;
    logic nc;
  } poa_in_cfg_t;
  typedef struct packed {
    logic estop;
    logic hold;
    logic servo_enable_input;
    logic stop;
  } poa_ctl_t;

  // Port index 7 first, index 0 last
  localparam poa_in_cfg_t [N_IN-1:0] IN_CFG_RESET = '{
    '{IN_NONE, 1'b0}, '{IN_STOP, 1'b0}, '{IN_NONE, 1'b0}, '{IN_SERVO_ENABLE_INPUT, 1'b0},
    '{IN_NONE, 1'b0}, '{IN_NONE, 1'b0}, '{IN_NONE, 1'b0}, '{IN_EMERGENCY_HALT_INPUT, 1'b1}};
  localparam poa_out_fn_t [N_OUT-1:0] OUT_CFG_RESET = '{
    OUT_BUSY, OUT_HEALTH, OUT_IN_POSITION_OUTPUT, OUT_DRIVE_READY_FUNCTION};

  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? (~v + 32'h00000001) : v;
  endfunction

  // Contact closed reads 1; normally closed inverts the meaning
  function automatic logic contact_on(input logic closed, input logic nc);
    return closed ^ nc;
  endfunction

endpackage

// >>> poa_port_map.sv
module poa_port_map (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [poa_pkg::N_IN-1:0] pin_in,
  input wire poa_pkg::poa_in_cfg_t [poa_pkg::N_IN-1:0] in_cfg,
  output poa_pkg::poa_ctl_t ctl
);
  import poa_pkg::*;

  logic [N_IN-1:0] sync1_ff;
  logic [N_IN-1:0] sync2_ff;
  logic emergency_halt_input_seen;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // Function decode
  // ----------------------------------------
  // Unassigned emergency halt input means run, so no mapping never halts the drive
  always_comb begin
    ctl = '0;
    emergency_halt_input_seen = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      case (in_cfg[i].fn)
        IN_EMERGENCY_HALT_INPUT: begin
          emergency_halt_input_seen = 1'b1;
          if (!contact_on(sync2_ff[i], in_cfg[i].nc)) ctl.estop = 1'b1;
        end
        IN_HOLD: ctl.hold = ctl.hold | contact_on(sync2_ff[i], in_cfg[i].nc);
        IN_SERVO_ENABLE_INPUT: ctl.servo_enable_input = ctl.servo_enable_input | contact_on(sync2_ff[i], in_cfg[i].nc);
        IN_STOP: ctl.stop = ctl.stop | contact_on(sync2_ff[i], in_cfg[i].nc);
        default: ;
      endcase
    end
    if (!emergency_halt_input_seen) ctl.estop = 1'b0;
  end

  property p_nc_unwired;
    @(posedge mclk) disable iff (!resetn)
    (in_cfg[4].fn == IN_SERVO_ENABLE_INPUT && in_cfg[4].nc && !sync2_ff[4]) |-> ctl.servo_enable_input;
  endproperty
  a_nc_unwired: assert property (p_nc_unwired) else $error("open nc servo input not on");

endmodule

// >>> poa_top.sv
module poa_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [poa_pkg::N_IN-1:0] pin_in,
  output logic [poa_pkg::N_OUT-1:0] pin_out,
  input wire logic password_entered,
  input wire logic param_wr,
  input wire logic param_sel,
  input wire logic [31:0] param_val,
  output logic param_rejected,
  input wire logic port_cfg_wr,
  input wire logic port_cfg_is_out,
  input wire logic [2:0] port_cfg_idx,
  input wire poa_pkg::poa_in_cfg_t port_cfg_in,
  input wire poa_pkg::poa_out_fn_t port_cfg_out,
  input wire logic prog_wr,
  input wire logic [poa_pkg::ADDR_W-1:0] prog_addr,
  input wire poa_pkg::poa_instr_t prog_data,
  input wire logic move_done,
  input wire logic alarm_in,
  input wire logic warning_in,
  input wire logic pos_lost_in,
  output logic move_valid,
  output logic [31:0] move_steps,
  output logic servo_on,
  output logic health_ok,
  output logic in_position,
  output logic busy,
  output logic cmd_error
);
  import poa_pkg::*;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_FETCH, ST_EXEC, ST_MOVE_WAIT, ST_DWELL
  } poa_state_t;

  poa_instr_t prog_mem [0:(1<<ADDR_W)-1];
  poa_instr_t rd_ff;
  poa_ctl_t ctl;

  poa_state_t st_ff, nxt_st;
  logic [CH_W-1:0] ch_ff, nxt_ch;
  logic [LINE_W-1:0] line_ff, nxt_line;
  logic [7:0] init_cnt_ff, nxt_init_cnt;
  logic mv_valid_ff, nxt_mv_valid;
  logic [31:0] mv_steps_ff, nxt_mv_steps;
  logic err_ff, nxt_err;
  logic dwell_start;
  logic dwell_done;
  logic [31:0] move_limit;

  logic unlock_ff, nxt_unlock;
  logic [8:0] as_ff, nxt_as;
  logic [21:0] div_ff, nxt_div;
  logic rej_ff, nxt_rej;

  poa_in_cfg_t [N_IN-1:0] in_cfg_ff, nxt_in_cfg;
  poa_out_fn_t [N_OUT-1:0] out_cfg_ff, nxt_out_cfg;

  logic [N_OUT-1:0] pin_ff, nxt_pin;
  logic servo_ff, nxt_servo;
  logic health_ff, nxt_health;
  logic in_position_output_ff, nxt_in_position_output;
  logic busy_ff, nxt_busy;
  logic drive_ready_function;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  poa_port_map u_port_map (
    .mclk(mclk),
    .resetn(resetn),
    .pin_in(pin_in),
    .in_cfg(in_cfg_ff),
    .ctl(ctl)
  );

  poa_dwell_timer u_dwell (
    .mclk(mclk),
    .resetn(resetn),
    .start(dwell_start),
    .tenths(rd_ff.arg[16:0]),
    .freeze(ctl.hold),
    .abort(ctl.estop),
    .done(dwell_done)
  );

  assign move_limit = {10'h000, div_ff} * MOVE_SCALE;

  // ----------------------------------------
  // Program store
  // ----------------------------------------
  // Read every cycle; EXEC sees the line addressed during FETCH
  always_ff @(posedge mclk) begin
    if (prog_wr) prog_mem[prog_addr] <= prog_data;
    rd_ff <= prog_mem[{ch_ff, line_ff}];
  end

  // ----------------------------------------
  // Protected parameters
  // ----------------------------------------
  // One password opens exactly one write
  always_comb begin
    nxt_as = as_ff;
    nxt_div = div_ff;
    nxt_unlock = unlock_ff;
    nxt_rej = 1'b0;
    if (param_wr) begin
      nxt_unlock = 1'b0;
      if (!unlock_ff) begin
        nxt_rej = 1'b1;
      end else if (!param_sel) begin
        if (param_val == MINUS_ONE || param_val <= CH_MAX) nxt_as = param_val[8:0];
        else nxt_rej = 1'b1;
      end else begin
        if (param_val >= {10'h000, DIV_MIN} && param_val <= {10'h000, DIV_MAX})
          nxt_div = param_val[21:0];
        else nxt_rej = 1'b1;
      end
    end
    if (password_entered) nxt_unlock = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      as_ff <= AUTOSTART_RESET;
      div_ff <= DIV_RESET;
      unlock_ff <= 1'b0;
      rej_ff <= 1'b0;
    end else begin
      as_ff <= nxt_as;
      div_ff <= nxt_div;
      unlock_ff <= nxt_unlock;
      rej_ff <= nxt_rej;
    end
  end

  // ----------------------------------------
  // Port function and polarity settings
  // ----------------------------------------
  always_comb begin
    nxt_in_cfg = in_cfg_ff;
    nxt_out_cfg = out_cfg_ff;
    if (port_cfg_wr) begin
      if (port_cfg_is_out) begin
        if (port_cfg_idx < 3'(N_OUT)) nxt_out_cfg[port_cfg_idx[1:0]] = port_cfg_out;
      end else begin
        nxt_in_cfg[port_cfg_idx] = port_cfg_in;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_cfg_ff <= IN_CFG_RESET;
      out_cfg_ff <= OUT_CFG_RESET;
    end else begin
      in_cfg_ff <= nxt_in_cfg;
      out_cfg_ff <= nxt_out_cfg;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Errors are sticky: recovery from an abnormal state is a reboot
  always_comb begin
    nxt_st = st_ff;
    nxt_ch = ch_ff;
    nxt_line = line_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_mv_valid = 1'b0;
    nxt_mv_steps = mv_steps_ff;
    nxt_err = err_ff;
    dwell_start = 1'b0;
    case (st_ff)
      ST_INIT: begin
        if (init_cnt_ff != 8'h00) begin
          nxt_init_cnt = init_cnt_ff - 8'h01;
        end else if (as_ff == AUTOSTART_OFF) begin
          nxt_st = ST_IDLE;
        end else begin
          nxt_ch = as_ff[7:0];
          nxt_line = LINE_FIRST;
          nxt_st = ST_FETCH;
        end
      end
      ST_IDLE: ;
      ST_FETCH: begin
        if (!ctl.hold) nxt_st = ST_EXEC;
      end
      ST_EXEC: begin
        case (rd_ff.op)
          OP_MOVE: begin
            if (abs32(rd_ff.arg) > move_limit) begin
              nxt_err = 1'b1;
              nxt_st = ST_IDLE;
            end else begin
              nxt_mv_valid = 1'b1;
              nxt_mv_steps = rd_ff.arg;
              nxt_st = ST_MOVE_WAIT;
            end
          end
          OP_DWELL: begin
            if (rd_ff.arg[31:17] != 15'h0000 || rd_ff.arg[16:0] < DWELL_MIN
                || rd_ff.arg[16:0] > DWELL_MAX) begin
              nxt_err = 1'b1;
              nxt_st = ST_IDLE;
            end else begin
              dwell_start = 1'b1;
              nxt_st = ST_DWELL;
            end
          end
          OP_GOTO: begin
            if (rd_ff.arg > CH_MAX) begin
              nxt_err = 1'b1;
              nxt_st = ST_IDLE;
            end else begin
              nxt_ch = rd_ff.arg[7:0];
              nxt_line = LINE_FIRST;
              nxt_st = ST_FETCH;
            end
          end
          default: nxt_st = ST_IDLE;
        endcase
      end
      ST_MOVE_WAIT, ST_DWELL: begin
        if ((st_ff == ST_MOVE_WAIT && move_done) || (st_ff == ST_DWELL && dwell_done)) begin
          if (line_ff == LINE_LAST) begin
            nxt_st = ST_IDLE;
          end else begin
            nxt_line = line_ff + 3'h1;
            nxt_st = ST_FETCH;
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (ctl.estop && st_ff != ST_INIT) begin
      nxt_st = ST_IDLE;
      nxt_mv_valid = 1'b0;
      dwell_start = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= ST_INIT;
      ch_ff <= '0;
      line_ff <= LINE_FIRST;
      init_cnt_ff <= 8'(INIT_CYCLES - 1);
      mv_valid_ff <= 1'b0;
      mv_steps_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ch_ff <= nxt_ch;
      line_ff <= nxt_line;
      init_cnt_ff <= nxt_init_cnt;
      mv_valid_ff <= nxt_mv_valid;
      mv_steps_ff <= nxt_mv_steps;
      err_ff <= nxt_err;
    end
  end

  // ----------------------------------------
  // Status outputs and port drive
  // ----------------------------------------
  // Outputs except in-position stay open until initialisation ends, so the host sees one clean edge
  always_comb begin
    nxt_servo = (st_ff != ST_INIT) && ctl.servo_enable_input && !ctl.estop;
    nxt_health = (st_ff != ST_INIT) && !alarm_in && !warning_in && !ctl.estop
                 && !err_ff;
    nxt_busy = (nxt_st == ST_FETCH) || (nxt_st == ST_EXEC) || (nxt_st == ST_MOVE_WAIT)
               || (nxt_st == ST_DWELL);
    nxt_in_position_output = in_position_output_ff;
    if (move_done) nxt_in_position_output = 1'b1;
    if (nxt_mv_valid || pos_lost_in) nxt_in_position_output = 1'b0;
    drive_ready_function = nxt_servo && nxt_health;
    for (int i = 0; i < N_OUT; i++) begin
      case (out_cfg_ff[i])
        OUT_DRIVE_READY_FUNCTION: nxt_pin[i] = drive_ready_function;
        OUT_HEALTH: nxt_pin[i] = nxt_health;
        OUT_IN_POSITION_OUTPUT: nxt_pin[i] = nxt_in_position_output;
        OUT_BUSY: nxt_pin[i] = nxt_busy;
        default: nxt_pin[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_ff <= '0;
      servo_ff <= 1'b0;
      health_ff <= 1'b0;
      in_position_output_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      servo_ff <= nxt_servo;
      health_ff <= nxt_health;
      in_position_output_ff <= nxt_in_position_output;
      busy_ff <= nxt_busy;
    end
  end

  assign pin_out = pin_ff;
  assign param_rejected = rej_ff;
  assign move_valid = mv_valid_ff;
  assign move_steps = mv_steps_ff;
  assign servo_on = servo_ff;
  assign health_ok = health_ff;
  assign in_position = in_position_output_ff;
  assign busy = busy_ff;
  assign cmd_error = err_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_launch;
    @(posedge mclk) disable iff (!resetn)
    (st_ff == ST_INIT && init_cnt_ff == 8'h00 && as_ff != AUTOSTART_OFF && !ctl.estop)
      |=> (st_ff == ST_FETCH && ch_ff == $past(as_ff[7:0]) && line_ff == LINE_FIRST);
  endproperty
  a_launch: assert property (p_launch) else $error("auto-start channel not launched");

  property p_no_launch;
    @(posedge mclk) disable iff (!resetn)
    (st_ff == ST_INIT && init_cnt_ff == 8'h00 && as_ff == AUTOSTART_OFF)
      |=> st_ff == ST_IDLE ##1 st_ff == ST_IDLE;
  endproperty
  a_no_launch: assert property (p_no_launch) else $error("launched with auto-start off");

  property p_div_range;
    @(posedge mclk) disable iff (!resetn)
    div_ff >= DIV_MIN && div_ff <= DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisions out of range");

  property p_move_limit;
    @(posedge mclk) disable iff (!resetn)
    mv_valid_ff |-> (abs32(mv_steps_ff) <= move_limit && st_ff == ST_MOVE_WAIT);
  endproperty
  a_move_limit: assert property (p_move_limit) else $error("move beyond limit");

  property p_goto;
    @(posedge mclk) disable iff (!resetn)
    (st_ff == ST_EXEC && rd_ff.op == OP_GOTO && rd_ff.arg <= CH_MAX && !ctl.estop)
      |=> (ch_ff == $past(rd_ff.arg[7:0]) && line_ff == LINE_FIRST && st_ff == ST_FETCH);
  endproperty
  a_goto: assert property (p_goto) else $error("goto did not redirect");

  property p_estop;
    @(posedge mclk) disable iff (!resetn)
    ctl.estop |=> (!servo_ff && !health_ff && !mv_valid_ff);
  endproperty
  a_estop: assert property (p_estop) else $error("drive active during stop");

  property p_hold;
    @(posedge mclk) disable iff (!resetn)
    (st_ff == ST_FETCH && ctl.hold && !ctl.estop) |=> st_ff == ST_FETCH;
  endproperty
  a_hold: assert property (p_hold) else $error("executed while held");

  property p_health;
    @(posedge mclk) disable iff (!resetn)
    (alarm_in || warning_in) |=> !health_ff;
  endproperty
  a_health: assert property (p_health) else $error("health closed during alarm");

  property p_in_position_output;
    @(posedge mclk) disable iff (!resetn)
    (pos_lost_in || mv_valid_ff) |=> !in_position_output_ff;
  endproperty
  a_in_position_output: assert property (p_in_position_output) else $error("in-position closed wrongly");

  property p_reject;
    @(posedge mclk) disable iff (!resetn)
    (param_wr && !unlock_ff) |=> (rej_ff && as_ff == $past(as_ff) && div_ff == $past(div_ff));
  endproperty
  a_reject: assert property (p_reject) else $error("locked write accepted");

  c_launch: cover property (@(posedge mclk) disable iff (!resetn)
    st_ff == ST_INIT ##1 st_ff == ST_FETCH);
  c_dwell: cover property (@(posedge mclk) disable iff (!resetn)
    st_ff == ST_DWELL ##1 st_ff == ST_FETCH);
  c_move: cover property (@(posedge mclk) disable iff (!resetn)
    mv_valid_ff ##[1:50] in_position_output_ff);

endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import poa_pkg::*;
  logic mclk, resetn, password_entered, param_wr, param_sel, param_rejected;
  logic [7:0] pin_in;
  logic [3:0] pin_out, delay;
  logic [31:0] param_val, move_steps;
  logic port_cfg_wr, port_cfg_is_out, prog_wr, move_done, alarm_in, warning_in;
  logic [2:0] port_cfg_idx;
  poa_in_cfg_t port_cfg_in;
  poa_out_fn_t port_cfg_out;
  logic [ADDR_W-1:0] prog_addr;
  poa_instr_t prog_data;
  logic pos_lost_in, move_valid, servo_on, health_ok, in_position, busy, cmd_error;
  logic run_req, hold_req;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int t_done = 0;
  int seed = 32'hc40f;
  logic [31:0] expq[$];
  poa_top poa_top_i (.mclk, .resetn, .pin_in, .pin_out, .password_entered, .param_wr,
    .param_sel, .param_val, .param_rejected, .port_cfg_wr, .port_cfg_is_out, .port_cfg_idx,
    .port_cfg_in, .port_cfg_out, .prog_wr, .prog_addr, .prog_data, .move_done, .alarm_in,
    .warning_in, .pos_lost_in, .move_valid, .move_steps, .servo_on, .health_ok,
    .in_position, .busy, .cmd_error);
  poa_host_model poa_host_model_i (.mclk, .run_req, .hold_req, .delay, .move_valid,
    .pin_in, .move_done);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic await(ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      tick(1);
      i++;
    end
    if (s !== v) begin
      $display("mismatch wait expected %h seen %h", v, s);
      fails++;
      wrap_up();
    end
  endtask
  task automatic wr_par(input logic pw, input logic sel, input logic [31:0] v,
                        input logic rej);
    @(posedge mclk);
    password_entered <= pw;
    @(posedge mclk);
    password_entered <= 1'b0;
    param_wr <= 1'b1;
    param_sel <= sel;
    param_val <= v;
    @(posedge mclk);
    param_wr <= 1'b0;
    #1 check("param_rejected", rej, param_rejected);
  endtask
  task automatic cfg(input logic o, input logic [2:0] ix, input poa_in_cfg_t c,
                     input poa_out_fn_t f);
    @(posedge mclk);
    port_cfg_wr <= 1'b1;
    port_cfg_is_out <= o;
    port_cfg_idx <= ix;
    port_cfg_in <= c;
    port_cfg_out <= f;
    @(posedge mclk);
    port_cfg_wr <= 1'b0;
  endtask
  task automatic prog(input logic [7:0] ch, input logic [2:0] ln, input poa_op_t op,
                      input logic [31:0] a);
    @(posedge mclk);
    prog_wr <= 1'b1;
    prog_addr <= {ch, ln};
    prog_data <= '{op, a};
    @(posedge mclk);
    prog_wr <= 1'b0;
  endtask
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (move_done === 1'b1) t_done <= cyc;
    if (move_valid === 1'b1) begin
      delay <= 4'($random(seed));
      if (expq.size() == 0) check("move_valid", 0, 1);
      else check("move_steps", expq.pop_front(), move_steps);
      if (move_steps === 32'hFFFFFFFD) check("pause", 1, cyc - t_done inside {[2000:2020]});
    end
  end
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {resetn, password_entered, param_wr, param_sel, port_cfg_wr, port_cfg_is_out} = '0;
    {prog_wr, alarm_in, warning_in, pos_lost_in, param_val, port_cfg_idx} = '0;
    {port_cfg_in, prog_addr, prog_data, delay} = '0;
    port_cfg_out = OUT_NONE;
    run_req = 1'b1;
    hold_req = 1'b1;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    wr_par(0, 1, 4, 1);
    wr_par(1, 1, 0, 1);
    wr_par(1, 1, 32'h00280001, 1);
    wr_par(1, 0, 32'h00000100, 1);
    wr_par(1, 1, 4, 0);
    wr_par(1, 0, 0, 0);
    cfg(0, 6, '{IN_HOLD, 1'b1}, OUT_NONE);
    cfg(0, 4, '{IN_SERVO_ENABLE_INPUT, 1'b1}, OUT_NONE);
    cfg(1, 0, '{IN_NONE, 1'b0}, OUT_HEALTH);
    prog(0, 0, OP_MOVE, 400);
    prog(0, 1, OP_DWELL, 1);
    prog(0, 2, OP_GOTO, 1);
    prog(1, 0, OP_MOVE, 32'hFFFFFFFD);
    prog(1, 1, OP_MOVE, 401);
    await(busy, 1'b1, 200);
    tick(20);
    check("busy", 1, busy);
    check("servo_on", 1, servo_on);
    check("health_ok", 1, health_ok);
    check("pin_out", 4'hD, pin_out);
    for (int i = 0; i < 2; i++) begin
      alarm_in <= (i == 0);
      warning_in <= (i == 1);
      tick(3);
      check("health_ok", 0, health_ok);
      alarm_in <= 1'b0;
      warning_in <= 1'b0;
      tick(3);
      check("health_ok", 1, health_ok);
    end
    expq.push_back(400);
    expq.push_back(32'hFFFFFFFD);
    hold_req <= 1'b0;
    await(in_position, 1'b1, 400);
    pos_lost_in <= 1'b1;
    tick(2);
    check("in_position", 0, in_position);
    pos_lost_in <= 1'b0;
    await(cmd_error, 1'b1, 4000);
    // Health follows the registered error flag one cycle later
    tick(1);
    check("health_ok", 0, health_ok);
    await(busy, 1'b0, 10);
    check("pending", 0, expq.size());
    check("servo_on", 1, servo_on);
    run_req <= 1'b0;
    tick(6);
    check("servo_on", 0, servo_on);
    // Mid-run reset: defaults return, auto-start is off again
    run_req <= 1'b1;
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(110);
    check("busy", 0, busy);
    check("cmd_error", 0, cmd_error);
    check("health_ok", 1, health_ok);
    check("servo_on", 0, servo_on);
    wrap_up();
  end
endmodule
